// >>> design/pcpc_regs.sv
// Purpose: Packet, clock-output and page configuration register bank
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low byte
// Notes:   Every access answers with one ack cycle after a one-cycle wait
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "pcpc_cfg.svh"
module pcpc_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             clkout,
    output logic             manchester_enable,
    output logic [6:0]       payload_length,
    output logic [7:0]       station_identifier,
    output logic             variable_length_mode,
    output logic             crc_enable,
    output logic [1:0]       addr_filter_mode,
    output logic             flush_on_checksum_fail,
    output logic             standby_queue_direction,
    output logic [1:0]       page_select,
    output logic             crc_result,
    input  wire logic        crc_check_done,
    input  wire logic        crc_check_pass,
    output logic             rx_fifo_flush,
    input  wire logic [7:0]  rx_addr_byte,
    input  wire logic        rx_addr_valid,
    output logic             rx_addr_accept,
    output logic             rx_addr_done
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    pcpc_pkg::pcpc_bus_state_type bus_state;
    pcpc_pkg::pcpc_bus_state_type next_bus_state;
    logic [31:0] next_wb_dat_o;
    logic        next_wb_ack_o;

    logic [7:0]  clock_output_control;
    logic [7:0]  packet_coding_and_length;
    logic [7:0]  station_id_reg;
    logic [7:0]  packet_format_control;
    logic [7:0]  page_and_fifo_select;
    logic [7:0]  next_clock_output_control;
    logic [7:0]  next_packet_coding_and_length;
    logic [7:0]  next_station_id_reg;
    logic [7:0]  next_packet_format_control;
    logic [7:0]  next_page_and_fifo_select;
    logic        next_rx_fifo_flush;

    logic        req;
    logic        word_ok;
    logic        page0;
    logic        hit_clkout;
    logic        hit_coding;
    logic        hit_station;
    logic        hit_format;
    logic        hit_page;
    logic        wr_commit;
    logic [7:0]  rd_byte;
    logic        clear_crc;
    logic        div_clkout;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    assign req         = wb_cyc_i && wb_stb_i;
    assign word_ok     = (wb_adr_i[1:0] == `PCPC_LANE_NONE);
    assign page0       = (page_and_fifo_select[1:0] == `PCPC_PAGE_0); // [RQ13]
    assign hit_clkout  = word_ok && page0 && (wb_adr_i[7:2] == `PCPC_IDX_CLKOUT);
    assign hit_coding  = word_ok && page0 && (wb_adr_i[7:2] == `PCPC_IDX_CODING);
    assign hit_station = word_ok && page0 && (wb_adr_i[7:2] == `PCPC_IDX_STATION);
    assign hit_format  = word_ok && page0 && (wb_adr_i[7:2] == `PCPC_IDX_FORMAT);
    assign hit_page    = word_ok && (wb_adr_i[7:2] == `PCPC_IDX_PAGE); // [RQ14]

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Page 1 registers live elsewhere; here they read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit_clkout) begin
            rd_byte = clock_output_control & `PCPC_MASK_CLKOUT; // [RQ15]
        end else if (hit_coding) begin
            rd_byte = packet_coding_and_length;
        end else if (hit_station) begin
            rd_byte = station_id_reg;
        end else if (hit_format) begin
            rd_byte = packet_format_control; // [RQ9]
        end else if (hit_page) begin
            rd_byte = page_and_fifo_select & `PCPC_MASK_PAGE; // [RQ15]
        end
    end

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Write lands on the ack edge, where the master samples ack
    always_comb begin
        next_bus_state = bus_state;
        next_wb_ack_o  = 1'b0;
        next_wb_dat_o  = wb_dat_o;
        wr_commit      = 1'b0;
        case (bus_state)
            pcpc_pkg::PCPC_BUS_IDLE: begin
                if (req) begin
                    next_bus_state = pcpc_pkg::PCPC_BUS_ACK;
                    next_wb_ack_o  = 1'b1;
                    next_wb_dat_o  = {24'h000000, rd_byte};
                end
            end
            pcpc_pkg::PCPC_BUS_ACK: begin
                wr_commit      = req && wb_we_i && wb_sel_i[0];
                next_bus_state = pcpc_pkg::PCPC_BUS_IDLE;
                next_wb_dat_o  = `PCPC_WORD_ZERO;
            end
            default: begin
                next_bus_state = pcpc_pkg::PCPC_BUS_IDLE;
                next_wb_dat_o  = `PCPC_WORD_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_state <= pcpc_pkg::PCPC_BUS_IDLE;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= `PCPC_WORD_ZERO;
        end else begin
            bus_state <= next_bus_state;
            wb_ack_o  <= next_wb_ack_o;
            wb_dat_o  <= next_wb_dat_o;
        end
    end

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    assign clear_crc = wr_commit && hit_format && wb_dat_i[`PCPC_BIT_CRC_STAT]; // [RQ10]

    always_comb begin
        next_clock_output_control     = clock_output_control;
        next_packet_coding_and_length = packet_coding_and_length;
        next_station_id_reg           = station_id_reg;
        next_packet_format_control    = packet_format_control;
        next_page_and_fifo_select     = page_and_fifo_select;
        if (wr_commit && hit_clkout) begin
            next_clock_output_control = wb_dat_i[7:0] & `PCPC_MASK_CLKOUT; // [RQ15]
        end
        if (wr_commit && hit_coding) begin
            next_packet_coding_and_length = wb_dat_i[7:0] & `PCPC_MASK_CODING;
        end
        if (wr_commit && hit_station) begin
            next_station_id_reg = wb_dat_i[7:0];
        end
        if (wr_commit && hit_format) begin
            next_packet_format_control[7:1] = wb_dat_i[7:1]; // [RQ9]
        end
        if (wr_commit && hit_page) begin
            next_page_and_fifo_select = wb_dat_i[7:0] & `PCPC_MASK_PAGE; // [RQ15]
        end
        // Fresh result beats a clear in the same cycle
        if (crc_check_done) begin
            next_packet_format_control[`PCPC_BIT_CRC_STAT] = crc_check_pass; // [RQ9]
        end else if (clear_crc) begin
            next_packet_format_control[`PCPC_BIT_CRC_STAT] = 1'b0; // [RQ10]
        end
        next_rx_fifo_flush = crc_check_done && !crc_check_pass &&
                             !page_and_fifo_select[`PCPC_BIT_TOP]; // [RQ11]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clock_output_control     <= `PCPC_RST_CLKOUT; // [RQ2]
            packet_coding_and_length <= `PCPC_RST_CODING; // [RQ4]
            station_id_reg           <= `PCPC_RST_STATION;
            packet_format_control    <= `PCPC_RST_FORMAT;
            page_and_fifo_select     <= `PCPC_RST_PAGE;
            rx_fifo_flush            <= 1'b0;
        end else begin
            clock_output_control     <= next_clock_output_control;
            packet_coding_and_length <= next_packet_coding_and_length;
            station_id_reg           <= next_station_id_reg;
            packet_format_control    <= next_packet_format_control;
            page_and_fifo_select     <= next_page_and_fifo_select;
            rx_fifo_flush            <= next_rx_fifo_flush;
        end
    end

    // ------------------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            manchester_enable       <= 1'b0;
            payload_length          <= 7'h00;
            station_identifier      <= `PCPC_RST_STATION;
            variable_length_mode    <= 1'b0;
            crc_enable              <= 1'b0;
            addr_filter_mode        <= 2'h0;
            flush_on_checksum_fail  <= 1'b0;
            standby_queue_direction <= 1'b0;
            page_select             <= `PCPC_PAGE_0;
            crc_result              <= 1'b0;
        end else begin
            manchester_enable       <= packet_coding_and_length[`PCPC_BIT_TOP]; // [RQ3]
            payload_length          <= packet_coding_and_length[6:0]; // [RQ4]
            station_identifier      <= station_id_reg; // [RQ5]
            variable_length_mode    <= packet_format_control[`PCPC_BIT_TOP]; // [RQ6]
            crc_enable              <= packet_format_control[`PCPC_BIT_CRC_EN]; // [RQ7]
            addr_filter_mode        <= packet_format_control[2:1]; // [RQ8]
            flush_on_checksum_fail  <= page_and_fifo_select[`PCPC_BIT_TOP]; // [RQ11]
            standby_queue_direction <= page_and_fifo_select[`PCPC_BIT_QUEUE_DIR]; // [RQ12]
            page_select             <= page_and_fifo_select[1:0]; // [RQ13]
            crc_result              <= packet_format_control[`PCPC_BIT_CRC_STAT]; // [RQ9]
        end
    end

    // ------------------------------------------------------------------------
    // Clock output and address filter
    // ------------------------------------------------------------------------
    pcpc_clkdiv u_clkdiv (
        .clk_sys (clk_sys),
        .rst     (rst),
        .enable  (clock_output_control[`PCPC_BIT_TOP]),
        .divisor (clock_output_control[6:2]),
        .clkout  (div_clkout)
    ); // [RQ1] [RQ2]

    assign clkout = div_clkout;

    pcpc_addr_filter u_addr_filter (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .mode       (packet_format_control[2:1]),
        .station_id (station_id_reg),
        .addr_byte  (rx_addr_byte),
        .addr_valid (rx_addr_valid),
        .accept     (rx_addr_accept),
        .done       (rx_addr_done)
    ); // [RQ5] [RQ8]
endmodule

// >>> design/pcpc_cfg.svh
// Purpose: Constants of the packet, clock-output and page configuration bank
// Assumes: Wishbone byte address = 4 * printed register index, data in low byte
// Notes:   Field outputs are registered copies of these registers
// Function
// RQ1: Clock output control bit 7 gates the divided clock onto the output pin.
// RQ2: Output runs at clock over twice divisor; divisor zero passes clock; reset 01111.
// RQ3: Coding register bit 7 turns Manchester coding on for both directions.
// RQ4: Seven-bit length, reset zero: fixed payload size or variable maximum length.
// RQ5: Station identifier byte is compared against received address bytes.
// RQ6: Format bit 7 picks fixed length when clear, variable length when set.
// RQ7: Format bit 3 enables checksum generation and checking.
// RQ8: Filter field: none, identifier, plus 0x00, plus 0x00 and 0xFF.
// RQ9: Format bit 0 is read-only checksum result, one meaning pass.
// RQ10: Writing one to bit 0 clears the result flag; writing zero does nothing.
// RQ11: Page bit 7 clear flushes the receive queue on failed checksum.
// RQ12: Page bit 6 picks write queue when clear, read queue when set, in standby.
// RQ13: Page field 00 maps page 0, 01 page 1, others map nothing.
// RQ14: Page register answers at 0x1F on every page.
// RQ15: Unused bits read zero and ignore writes.
`ifndef PCPC_CFG_SVH
`define PCPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define PCPC_IDX_CLKOUT      6'h1B
`define PCPC_IDX_CODING      6'h1C
`define PCPC_IDX_STATION     6'h1D
`define PCPC_IDX_FORMAT      6'h1E
`define PCPC_IDX_PAGE        6'h1F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PCPC_RST_CLKOUT      8'hBC
`define PCPC_RST_CODING      8'h00
`define PCPC_RST_STATION     8'h00
`define PCPC_RST_FORMAT      8'h40
`define PCPC_RST_PAGE        8'h00

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define PCPC_BIT_TOP         7
`define PCPC_BIT_QUEUE_DIR   6
`define PCPC_BIT_CRC_EN      3
`define PCPC_BIT_CRC_STAT    0
`define PCPC_MASK_CLKOUT     8'hFC
`define PCPC_MASK_CODING     8'hFF
`define PCPC_MASK_FORMAT_RW  8'hFE
`define PCPC_MASK_PAGE       8'hC3
`define PCPC_PAGE_0          2'h0
`define PCPC_PAGE_1          2'h1
`define PCPC_ADDR_ZERO       8'h00
`define PCPC_ADDR_BCAST      8'hFF
`define PCPC_DIV_ZERO        5'h00
`define PCPC_DIV_STEP        5'h01
`define PCPC_LANE_NONE       2'h0
`define PCPC_WORD_ZERO       32'h0000_0000

`endif

// >>> design/pcpc_pkg.sv
// Purpose: Types of the packet, clock-output and page configuration bank
// Assumes: Constants live in pcpc_cfg.svh
// Notes:   Encodings written out
package pcpc_pkg;
    typedef enum logic {
        PCPC_BUS_IDLE = 1'b0,
        PCPC_BUS_ACK  = 1'b1
    } pcpc_bus_state_type;

    typedef enum logic [1:0] {
        PCPC_FILT_NONE  = 2'b00,
        PCPC_FILT_ID    = 2'b01,
        PCPC_FILT_ID_Z  = 2'b10,
        PCPC_FILT_ID_ZB = 2'b11
    } pcpc_filter_mode_type;
endpackage

// >>> design/pcpc_clkdiv.sv
// Purpose: Buffered clock output divider
// Assumes: clk_sys is the crystal clock
// Notes:   Divisor zero bypasses the divider
`timescale 1ns/1ps
`include "pcpc_cfg.svh"
module pcpc_clkdiv (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic [4:0] divisor,
    output logic            clkout
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       phase;
    logic       next_phase;
    logic       bypass;
    logic       next_bypass;

    // ------------------------------------------------------------------------
    // Half-period counter
    // ------------------------------------------------------------------------
    always_comb begin
        next_count  = count;
        next_phase  = phase;
        next_bypass = enable && (divisor == `PCPC_DIV_ZERO); // [RQ2]
        if (!enable || divisor == `PCPC_DIV_ZERO) begin
            next_count = `PCPC_DIV_ZERO;
            next_phase = 1'b0;
        end else if (count >= divisor - `PCPC_DIV_STEP) begin
            next_count = `PCPC_DIV_ZERO;
            next_phase = !phase; // [RQ2]
        end else begin
            next_count = count + `PCPC_DIV_STEP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count  <= `PCPC_DIV_ZERO;
            phase  <= 1'b0;
            bypass <= 1'b0;
        end else begin
            count  <= next_count;
            phase  <= next_phase;
            bypass <= next_bypass;
        end
    end

    // Undivided rate cannot come from a flop; bypass gates the clock itself
    assign clkout = bypass ? clk_sys : phase; // [RQ1]
endmodule

// >>> design/pcpc_addr_filter.sv
// Purpose: Received address byte filter
// Assumes: addr_valid is a one-cycle strobe with addr_byte
// Notes:   Verdict registered one cycle after the strobe
`timescale 1ns/1ps
`include "pcpc_cfg.svh"
module pcpc_addr_filter (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] station_id,
    input  wire logic [7:0] addr_byte,
    input  wire logic       addr_valid,
    output logic            accept,
    output logic            done
);
    logic next_accept;
    logic match;

    // ------------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------------
    always_comb begin
        match = 1'b0;
        case (pcpc_pkg::pcpc_filter_mode_type'(mode))
            pcpc_pkg::PCPC_FILT_NONE:  match = 1'b1; // [RQ8]
            pcpc_pkg::PCPC_FILT_ID:    match = (addr_byte == station_id); // [RQ5] [RQ8]
            pcpc_pkg::PCPC_FILT_ID_Z:  match = (addr_byte == station_id) ||
                                               (addr_byte == `PCPC_ADDR_ZERO); // [RQ8]
            pcpc_pkg::PCPC_FILT_ID_ZB: match = (addr_byte == station_id) || (addr_byte == `PCPC_ADDR_ZERO) ||
                                               (addr_byte == `PCPC_ADDR_BCAST); // [RQ8]
            default:                   match = 1'b0;
        endcase
        next_accept = addr_valid ? match : accept;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            accept <= 1'b0;
            done   <= 1'b0;
        end else begin
            accept <= next_accept;
            done   <= addr_valid;
        end
    end
endmodule

// >>> verification/pcpc_regs_asserts.sv
// Purpose: Port checks of the config bank
// Assumes: Fields follow a write two edges later
// Notes:   Gated clock at divisor zero not sampled
`timescale 1ns/1ps
module pcpc_regs_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        clkout,
    input wire logic        manchester_enable,
    input wire logic [6:0]  payload_length,
    input wire logic [7:0]  station_identifier,
    input wire logic        variable_length_mode,
    input wire logic        crc_enable,
    input wire logic [1:0]  addr_filter_mode,
    input wire logic        flush_on_checksum_fail,
    input wire logic        standby_queue_direction,
    input wire logic [1:0]  page_select,
    input wire logic        crc_result,
    input wire logic        crc_check_done,
    input wire logic        crc_check_pass,
    input wire logic        rx_fifo_flush,
    input wire logic [7:0]  rx_addr_byte,
    input wire logic        rx_addr_valid,
    input wire logic        rx_addr_accept,
    input wire logic        rx_addr_done
);
    // ------------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------------
    logic       wr;
    logic       fok;
    logic [7:0] d1;
    logic [7:0] d2;
    assign wr  = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && page_select == 2'h0;
    assign fok = addr_filter_mode == 2'h0 || rx_addr_byte == station_identifier
                 || (addr_filter_mode[1] && rx_addr_byte == 8'h00)
                 || (addr_filter_mode == 2'h3 && rx_addr_byte == 8'hFF);
    always_ff @(posedge clk_sys) begin
        d1 <= wb_dat_i[7:0];
        d2 <= d1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_clk_off;
        wr && wb_adr_i == 8'h6C && !wb_dat_i[7] |-> ##4 (!clkout) [*8];
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clkout runs disabled");
    property p_coding;
        wr && wb_adr_i == 8'h70 |-> ##2 {manchester_enable, payload_length} == d2;
    endproperty
    a_coding: assert property (p_coding) else $error("coding wrong");
    property p_station;
        wr && wb_adr_i == 8'h74 |-> ##2 station_identifier == d2;
    endproperty
    a_station: assert property (p_station) else $error("station wrong");
    property p_format;
        wr && wb_adr_i == 8'h78 |-> ##2 {variable_length_mode, crc_enable, addr_filter_mode} == {d2[7], d2[3], d2[2:1]};
    endproperty
    a_format: assert property (p_format) else $error("format wrong");
    property p_result;
        crc_check_done |-> ##2 crc_result == $past(crc_check_pass, 2);
    endproperty
    a_result: assert property (p_result) else $error("flag wrong");
    property p_clear;
        wr && wb_adr_i == 8'h78 && wb_dat_i[0] && !crc_check_done |-> ##2 !crc_result;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_flush;
        rx_fifo_flush == $past(crc_check_done && !crc_check_pass && !flush_on_checksum_fail);
    endproperty
    a_flush: assert property (p_flush) else $error("flush wrong");
    property p_page;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h7C |-> ##2
            {flush_on_checksum_fail, standby_queue_direction, page_select} == {d2[7:6], d2[1:0]};
    endproperty
    a_page: assert property (p_page) else $error("page wrong");
    property p_filter;
        rx_addr_valid |=> rx_addr_done && rx_addr_accept == $past(fok);
    endproperty
    a_filter: assert property (p_filter) else $error("verdict wrong");
    property p_unused;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000 && (wb_adr_i != 8'h6C || wb_dat_o[1:0] == 2'h0)
            && (wb_adr_i != 8'h7C || wb_dat_o[5:2] == 4'h0);
    endproperty
    a_unused: assert property (p_unused) else $error("unused nonzero");
    c_clear: cover property (wr && wb_adr_i == 8'h78 && wb_dat_i[0]);
    c_flush: cover property (rx_fifo_flush);
    c_accept: cover property (rx_addr_done && rx_addr_accept);
endmodule

bind pcpc_regs pcpc_regs_asserts i_pcpc_regs_asserts (.*);

// >>> verification/pcpc_host_model.sv
// Purpose: Host side of the register bus
// Assumes: access is entered right after a rising edge of clk_sys
// Notes:   Released data shows the inverse
`timescale 1ns/1ps
module pcpc_host_model (
    input  wire logic        clk_sys,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic [7:0]       wb_adr_i,
    output logic [3:0]       wb_sel_i,
    output logic [31:0]      wb_dat_i
);
    // ------------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------------
    initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [7:0] wd, output logic [7:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, wd};
        @(posedge clk_sys);
        // Watchdog cuts a hang
        while (wb_ack_o !== 1'b1) @(posedge clk_sys);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_dat_i <= ~wb_dat_i;
        @(posedge clk_sys);
    endtask
endmodule

// >>> verification/packet_clock_page_config_regs_test.sv
// Purpose: Directed test of the configuration register bank
// Assumes: Host model drives the bus
// Notes:   Divisor zero not measured
`timescale 1ns/1ps
module packet_clock_page_config_regs_test;
    // ------------------------------------------------------------------
    // Wiring, tasks and sequence
    // ------------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        crc_check_done = 1'b0;
    logic        crc_check_pass = 1'b0;
    logic        rx_addr_valid = 1'b0;
    logic [7:0]  rx_addr_byte = 8'h00;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clkout, rx_fifo_flush, rx_addr_accept, rx_addr_done;
    logic [7:0]  wb_adr_i, station_identifier;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        manchester_enable, variable_length_mode, crc_enable, crc_result;
    logic        flush_on_checksum_fail, standby_queue_direction;
    logic [6:0]  payload_length;
    logic [1:0]  addr_filter_mode, page_select;
    logic [7:0]  rd;
    int          n;
    int          err_total = 0;
    int          checks = 0;
    logic [7:0]  rst_v [5] = '{8'hBC, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [7:0]  mask_v [4] = '{8'hFC, 8'hFF, 8'hFF, 8'hFE};
    logic [7:0]  tst_b [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    always #12.5 clk_sys = ~clk_sys;
    pcpc_regs i_pcpc_regs (.*);
    pcpc_host_model i_pcpc_host_model (.*);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        i_pcpc_host_model.access(1'b1, adr, 4'h1, v, rd);
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
        i_pcpc_host_model.access(1'b0, adr, 4'h1, 8'h00, rd);
        chk($sformatf("reg %h", adr), exp, rd);
    endtask
    task automatic hi_len(output int cnt);
        cnt = 0;
        while (clkout === 1'b1) @(posedge clk_sys);
        while (clkout !== 1'b1) @(posedge clk_sys);
        while (clkout === 1'b1) begin
            cnt++;
            @(posedge clk_sys);
        end
    endtask
    task automatic crc_ev(input logic pass, input logic exp_flush);
        crc_check_done <= 1'b1;
        crc_check_pass <= pass;
        @(posedge clk_sys);
        crc_check_done <= 1'b0;
        crc_check_pass <= ~pass;
        @(posedge clk_sys);
        chk("flush", {7'h00, exp_flush}, {7'h00, rx_fifo_flush});
    endtask
    task automatic addr_ev(input logic [7:0] b, input logic exp);
        rx_addr_valid <= 1'b1;
        rx_addr_byte  <= b;
        @(posedge clk_sys);
        rx_addr_valid <= 1'b0;
        rx_addr_byte  <= ~b;
        @(posedge clk_sys);
        chk($sformatf("verdict %h", b), {6'h00, 1'b1, exp}, {6'h00, rx_addr_done, rx_addr_accept});
    endtask
    task automatic test_done;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) rchk(8'h6C + 8'(4 * i), rst_v[i]);
        hi_len(n);
        chk("high time reset", 8'h0F, 8'(n));
        wr(8'h6C, 8'h84);
        hi_len(n);
        hi_len(n);
        chk("high time one", 8'h01, 8'(n));
        wr(8'h6C, 8'h3C);
        repeat (4) @(posedge clk_sys);
        n = 0;
        repeat (40) begin
            @(posedge clk_sys);
            n += (clkout !== 1'b0);
        end
        chk("clock off", 8'h00, 8'(n));
        for (int i = 0; i < 4; i++) begin
            wr(8'h6C + 8'(4 * i), 8'hFF);
            rchk(8'h6C + 8'(4 * i), mask_v[i]);
            wr(8'h6C + 8'(4 * i), 8'h00);
            rchk(8'h6C + 8'(4 * i), 8'h00);
        end
        // Lane off, misaligned, unmapped
        i_pcpc_host_model.access(1'b1, 8'h74, 4'hE, 8'h77, rd);
        wr(8'h75, 8'h11);
        rchk(8'h74, 8'h00);
        rchk(8'h80, 8'h00);
        wr(8'h7C, 8'hFF);
        rchk(8'h7C, 8'hC3);
        wr(8'h74, 8'h99);
        rchk(8'h74, 8'h00);
        wr(8'h7C, 8'h01);
        rchk(8'h70, 8'h00);
        rchk(8'h7C, 8'h01);
        wr(8'h7C, 8'h00);
        rchk(8'h74, 8'h00);
        wr(8'h74, 8'h5A);
        rchk(8'h74, 8'h5A);
        crc_ev(1'b1, 1'b0);
        rchk(8'h78, 8'h01);
        wr(8'h78, 8'h00);
        rchk(8'h78, 8'h01);
        wr(8'h78, 8'h01);
        rchk(8'h78, 8'h00);
        crc_ev(1'b1, 1'b0);
        crc_ev(1'b0, 1'b1);
        rchk(8'h78, 8'h00);
        wr(8'h7C, 8'h80);
        crc_ev(1'b0, 1'b0);
        wr(8'h7C, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(8'h78, {5'h00, 2'(m), 1'b0});
            for (int b = 0; b < 4; b++)
                addr_ev(tst_b[b], m == 0 || b == 0 || (m >= 2 && b == 1) || (m == 3 && b == 2));
        end
        test_done;
    end
endmodule
